// [logic/dwd_regs.svh]
`ifndef DWD_REGS_SVH
`define DWD_REGS_SVH

// cpu clock rate that the window watchdog time figures are quoted at
`define DWD_CPU_MHZ           16
`define DWD_WWD_MIN_US        75
`define DWD_WWD_MAX_US        64000
// cpu clock ticks per downcounter step (one step = shortest time-out)
`define DWD_WWD_STEP_TICKS    (`DWD_WWD_MIN_US * `DWD_CPU_MHZ)
// longest time-out in steps, rounded down
`define DWD_WWD_MAX_STEPS     (`DWD_WWD_MAX_US / `DWD_WWD_MIN_US)

`define DWD_RC_KHZ            128
`define DWD_IWD_MIN_US        60
`define DWD_IWD_MAX_US        1000000
// least time rounds up, longest rounds down, in low speed clock edges
`define DWD_IWD_MIN_EDGES     ((`DWD_IWD_MIN_US * `DWD_RC_KHZ + 999) / 1000)
`define DWD_IWD_MAX_EDGES     (`DWD_IWD_MAX_US * `DWD_RC_KHZ / 1000)

`define DWD_WWD_WIDTH         10
`define DWD_IWD_WIDTH         17
`define DWD_COUNT_RST         0

`endif

// [logic/dwd_pkg.sv]
`default_nettype none
package dwd_pkg;

  typedef enum logic [1:0] {
    st_idle  = 2'b00,
    st_run   = 2'b01,
    st_fired = 2'b11
  } dwd_state_e;

  function automatic logic [31:0] dwd_clamp(input logic [31:0] v,
                                            input logic [31:0] lo,
                                            input logic [31:0] hi);
    logic [31:0] r;
    r = v;
    if (v < lo) begin
      r = lo;
    end else if (v > hi) begin
      r = hi;
    end
    return r;
  endfunction : dwd_clamp

endpackage : dwd_pkg
`default_nettype wire

// [logic/dwd_indep.sv]
`timescale 1ns/100ps
`default_nettype none
`include "dwd_regs.svh"

module dwd_indep #(
  parameter int unsigned IWD_W         = `DWD_IWD_WIDTH,
  parameter int unsigned IWD_MIN_EDGES = `DWD_IWD_MIN_EDGES,
  parameter int unsigned IWD_MAX_EDGES = `DWD_IWD_MAX_EDGES
) (
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  input  wire logic             low_speed_rc_clock,
  input  wire logic             go,
  input  wire logic             refresh,
  input  wire logic [IWD_W-1:0] reload,
  output var  logic             active,
  output var  logic [IWD_W-1:0] count,
  output var  logic             fired
);
  import dwd_pkg::*;

  logic             rc_q;
  wire  logic       rc_rise;
  wire  logic       good_refresh;
  wire  logic       expire;
  wire  logic [IWD_W-1:0] reload_val;
  logic [IWD_W-1:0] next_count;

  //////////////////////////////////////////////////////////////////////////
  // time base is the low speed clock only; cpu_tick never enters here
  assign rc_rise      = low_speed_rc_clock && !rc_q;
  assign good_refresh = active && refresh && !fired;
  assign expire       = active && !fired && rc_rise && (count <= IWD_W'(1)) && !refresh;
  assign reload_val   = IWD_W'(dwd_clamp(32'(reload), IWD_MIN_EDGES, IWD_MAX_EDGES));

  always_comb begin
    next_count = count;
    if (go && !active) begin
      next_count = reload_val;
    end else if (good_refresh) begin
      next_count = reload_val;
    end else if (active && !fired && rc_rise && count != 0) begin
      next_count = count - IWD_W'(1);
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rc_q   <= 1'b0;
      active <= 1'b0;
      count  <= IWD_W'(`DWD_COUNT_RST);
      fired  <= 1'b0;
    end else begin
      rc_q   <= low_speed_rc_clock;
      active <= active | go;
      count  <= next_count;
      fired  <= fired | expire;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  chk_iwd_stays_on: assert property (@(posedge core_clk) disable iff (!rst_n)
    active |=> active) else $error("independent watchdog turned off");

  chk_iwd_rc_only: assert property (@(posedge core_clk) disable iff (!rst_n)
    (active && !rc_rise && !refresh) |=> $stable(count))
    else $error("independent count moved without low speed edge");

  chk_iwd_decrement: assert property (@(posedge core_clk) disable iff (!rst_n)
    (active && !fired && rc_rise && !refresh && count > 1) |=> (count == $past(count) - 1))
    else $error("independent count missed a low speed edge");

  chk_iwd_timeout: assert property (@(posedge core_clk) disable iff (!rst_n)
    (active && rc_rise && count == 1 && !refresh) |=> fired)
    else $error("independent time-out not flagged");

  chk_iwd_reload: assert property (@(posedge core_clk) disable iff (!rst_n)
    (active && !fired && refresh) |=> (count == $past(reload_val)))
    else $error("independent refresh did not reload");

endmodule : dwd_indep
`default_nettype wire

// [logic/dwd_top.sv]
// Behaviour
// - each watchdog starts from its option strap at reset or a software write.
// - once active, writes of zero are ignored; only reset stops a watchdog.
// - window downcounter reaching zero requests a device reset.
// - refresh while count is above the window value requests a device reset.
// - independent counter steps on the low speed clock, not the cpu clock.
// - independent watchdog keeps counting and resetting when cpu clock fails.
// - independent time-out programmable from about 60 us to about 1 s.

`timescale 1ns/100ps
`default_nettype none
`include "dwd_regs.svh"

module dwd_top #(
  parameter int unsigned WWD_W          = `DWD_WWD_WIDTH,
  parameter int unsigned IWD_W          = `DWD_IWD_WIDTH,
  parameter int unsigned WWD_STEP_TICKS = `DWD_WWD_STEP_TICKS,
  parameter int unsigned WWD_MAX_STEPS  = `DWD_WWD_MAX_STEPS,
  parameter int unsigned IWD_MIN_EDGES  = `DWD_IWD_MIN_EDGES,
  parameter int unsigned IWD_MAX_EDGES  = `DWD_IWD_MAX_EDGES
) (
  input  wire logic             core_clk,
  input  wire logic             nrst,
  input  wire logic             cpu_tick,
  input  wire logic             low_speed_rc_clock,
  input  wire logic             wwd_option_on,
  input  wire logic             iwd_option_on,
  input  wire logic             wwd_ctrl_wr,
  input  wire logic             wwd_ctrl_en,
  input  wire logic             wwd_refresh,
  input  wire logic [WWD_W-1:0] wwd_reload,
  input  wire logic [WWD_W-1:0] wwd_window,
  input  wire logic             iwd_ctrl_wr,
  input  wire logic             iwd_ctrl_en,
  input  wire logic             iwd_refresh,
  input  wire logic [IWD_W-1:0] iwd_reload,
  output var  dwd_pkg::dwd_state_e wwd_state,
  output var  logic [WWD_W-1:0] wwd_count,
  output var  logic             iwd_active,
  output var  logic [IWD_W-1:0] iwd_count,
  output var  logic             iwd_fired,
  output var  logic             device_reset_req
);
  import dwd_pkg::*;

  localparam int unsigned SCW = $clog2(WWD_STEP_TICKS + 1);
  localparam logic [SCW-1:0] STEP_LAST = SCW'(WWD_STEP_TICKS - 1);

  logic [1:0]       rst_sync;
  wire  logic       rst_n;
  logic             started;
  logic [SCW-1:0]   step_cnt;
  logic [SCW-1:0]   next_step_cnt;
  dwd_state_e       next_state;
  logic [WWD_W-1:0] next_count;

  wire  logic       start_pulse;
  wire  logic       wwd_go;
  wire  logic       iwd_go;
  wire  logic       running;
  wire  logic       wwd_step;
  wire  logic       wwd_early;
  wire  logic       wwd_good;
  wire  logic       wwd_expire;
  wire  logic [WWD_W-1:0] reload_val;

  //////////////////////////////////////////////////////////////////////////
  // reset release through two flops; only the second is used downstream
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // straps are sampled on the first edge after release, never at reset
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      started <= 1'b0;
    end else begin
      started <= 1'b1;
    end
  end
  assign start_pulse = !started;

  //////////////////////////////////////////////////////////////////////////
  // activation: strap or a write of one; a write of zero does nothing
  assign wwd_go = (start_pulse && wwd_option_on) || (wwd_ctrl_wr && wwd_ctrl_en);
  assign iwd_go = (start_pulse && iwd_option_on) || (iwd_ctrl_wr && iwd_ctrl_en);

  //////////////////////////////////////////////////////////////////////////
  // window watchdog, stepped by cpu clock ticks
  assign running    = (wwd_state == st_run);
  assign wwd_step   = running && cpu_tick && (step_cnt == STEP_LAST);
  assign wwd_early  = running && wwd_refresh && (wwd_count > wwd_window);
  // a refresh inside the window in the expiry cycle still counts as in time
  assign wwd_good   = running && wwd_refresh && !wwd_early;
  assign wwd_expire = wwd_step && (wwd_count <= WWD_W'(1)) && !wwd_good;
  assign reload_val = WWD_W'(dwd_clamp(32'(wwd_reload), 32'd1, WWD_MAX_STEPS));

  always_comb begin
    next_state = wwd_state;
    case (wwd_state)
      st_idle: begin
        if (wwd_go) begin
          next_state = st_run;
        end
      end
      st_run: begin
        if (wwd_early || wwd_expire) begin
          next_state = st_fired;
        end
      end
      st_fired: begin
        next_state = st_fired;
      end
      default: begin
        next_state = st_idle;
      end
    endcase
  end

  always_comb begin
    next_count = wwd_count;
    if (wwd_state == st_idle && wwd_go) begin
      next_count = reload_val;
    end else if (wwd_good) begin
      next_count = reload_val;
    end else if (wwd_step && wwd_count != 0) begin
      next_count = wwd_count - WWD_W'(1);
    end
  end

  always_comb begin
    next_step_cnt = step_cnt;
    if (wwd_good || (wwd_state == st_idle && wwd_go)) begin
      next_step_cnt = '0;
    end else if (running && cpu_tick) begin
      next_step_cnt = (step_cnt == STEP_LAST) ? '0 : step_cnt + SCW'(1);
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wwd_state        <= st_idle;
      wwd_count        <= WWD_W'(`DWD_COUNT_RST);
      step_cnt         <= '0;
      device_reset_req <= 1'b0;
    end else begin
      wwd_state        <= next_state;
      wwd_count        <= next_count;
      step_cnt         <= next_step_cnt;
      // held until nrst; iwd request arrives one edge after its flag
      device_reset_req <= device_reset_req | wwd_early | wwd_expire | iwd_fired;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // independent watchdog: core_clk must keep running, cpu_tick may stop
  dwd_indep #(
    .IWD_W         (IWD_W),
    .IWD_MIN_EDGES (IWD_MIN_EDGES),
    .IWD_MAX_EDGES (IWD_MAX_EDGES)
  ) u_indep (
    .core_clk           (core_clk),
    .rst_n              (rst_n),
    .low_speed_rc_clock (low_speed_rc_clock),
    .go                 (iwd_go),
    .refresh            (iwd_refresh),
    .reload             (iwd_reload),
    .active             (iwd_active),
    .count              (iwd_count),
    .fired              (iwd_fired)
  );

  //////////////////////////////////////////////////////////////////////////
  chk_wwd_sw_start: assert property (@(posedge core_clk) disable iff (!rst_n)
    (wwd_state == st_idle && wwd_ctrl_wr && wwd_ctrl_en) |=> (wwd_state == st_run))
    else $error("window watchdog did not start on write");

  chk_wwd_stays_on: assert property (@(posedge core_clk) disable iff (!rst_n)
    (wwd_state != st_idle) |=> (wwd_state != st_idle))
    else $error("window watchdog turned off");

  chk_wwd_timeout: assert property (@(posedge core_clk) disable iff (!rst_n)
    (running && cpu_tick && step_cnt == STEP_LAST && wwd_count == 1 && !wwd_refresh)
    |=> (wwd_state == st_fired) ##1 device_reset_req)
    else $error("window time-out did not reset");

  chk_wwd_early: assert property (@(posedge core_clk) disable iff (!rst_n)
    (running && wwd_refresh && wwd_count > wwd_window) |=> (wwd_state == st_fired))
    else $error("early refresh not punished");

  chk_wwd_reload: assert property (@(posedge core_clk) disable iff (!rst_n)
    (running && wwd_refresh && wwd_count <= wwd_window)
    |=> (wwd_state == st_run && wwd_count == $past(reload_val) && step_cnt == 0))
    else $error("window refresh did not reload");

  chk_wwd_step: assert property (@(posedge core_clk) disable iff (!rst_n)
    (running && cpu_tick && step_cnt == STEP_LAST && !wwd_refresh && wwd_count > 1)
    |=> (wwd_count == $past(wwd_count) - 1))
    else $error("window count missed a step");

  chk_iwd_reset: assert property (@(posedge core_clk) disable iff (!rst_n)
    iwd_fired |=> device_reset_req)
    else $error("independent time-out did not reset");

  // strap is looked at only on the first edge after the internal reset release
  chk_wwd_strap_start: assert property (@(posedge core_clk) disable iff (!rst_n)
    (start_pulse && wwd_option_on) |=> (wwd_state == st_run))
    else $error("window watchdog strap ignored");

  chk_iwd_strap_start: assert property (@(posedge core_clk) disable iff (!rst_n)
    (start_pulse && iwd_option_on) |=> iwd_active)
    else $error("independent watchdog strap ignored");

  chk_wwd_fired_req: assert property (@(posedge core_clk) disable iff (!rst_n)
    (wwd_state == st_fired) |-> device_reset_req)
    else $error("window watchdog fired without reset request");

endmodule : dwd_top
`default_nettype wire

// [sim/tb.sv]
`timescale 1ns/100ps
`default_nettype none

module tb;
  import dwd_pkg::*;

  logic core_clk = 1'b0, nrst = 1'b0, cpu_tick = 1'b0, rc_clk = 1'b0, rc_run = 1'b0;
  logic wwd_opt = 1'b0, iwd_opt = 1'b0, wwd_wr = 1'b0, wwd_en = 1'b0, wwd_ref = 1'b0;
  logic iwd_wr = 1'b0, iwd_en = 1'b0, iwd_ref = 1'b0;
  logic [9:0]  wwd_reload = 10'h001, wwd_window = 10'h3FF;
  logic [16:0] iwd_reload = 17'h00008;
  dwd_state_e  wwd_state;
  logic [9:0]  wwd_count;
  logic [16:0] iwd_count;
  logic        iwd_active, iwd_fired, rst_req;
  int          fails = 0, checks_done = 0, cycles = 0, rc_div = 0, n;

  always #50 core_clk = ~core_clk;

  // rc clock stand-in: 78 core cycles a period, about 128 kHz
  always @(negedge core_clk) begin
    if (rc_run) begin
      if (rc_div == 38) begin
        rc_div <= 0;
        rc_clk <= ~rc_clk;
      end else begin
        rc_div <= rc_div + 1;
      end
    end
  end

  // step ticks and max edges shortened so the run stays short
  dwd_top #(.WWD_STEP_TICKS(4), .IWD_MAX_EDGES(64)) dwd_top_inst (
    .core_clk(core_clk), .nrst(nrst), .cpu_tick(cpu_tick), .low_speed_rc_clock(rc_clk),
    .wwd_option_on(wwd_opt), .iwd_option_on(iwd_opt), .wwd_ctrl_wr(wwd_wr),
    .wwd_ctrl_en(wwd_en), .wwd_refresh(wwd_ref), .wwd_reload(wwd_reload),
    .wwd_window(wwd_window), .iwd_ctrl_wr(iwd_wr), .iwd_ctrl_en(iwd_en),
    .iwd_refresh(iwd_ref), .iwd_reload(iwd_reload), .wwd_state(wwd_state),
    .wwd_count(wwd_count), .iwd_active(iwd_active), .iwd_count(iwd_count),
    .iwd_fired(iwd_fired), .device_reset_req(rst_req));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : check

  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : print_verdict

  // reset held 16 cycles; straps settle before release
  task automatic do_reset(input logic w_strap, input logic i_strap);
    @(negedge core_clk);
    nrst    = 1'b0;
    wwd_opt = w_strap;
    iwd_opt = i_strap;
    repeat (16) @(negedge core_clk);
    check({rst_req, iwd_active, wwd_state}, 32'h0);
    nrst = 1'b1;
    repeat (5) @(negedge core_clk);
  endtask : do_reset

  // one-cycle control strobes, changed at the falling edge only
  task automatic wwd_write(input logic en, input logic [9:0] rl, input logic [9:0] win);
    wwd_en     = en;
    wwd_reload = rl;
    wwd_window = win;
    wwd_wr     = 1'b1;
    @(negedge core_clk);
    wwd_wr = 1'b0;
    @(negedge core_clk);
  endtask : wwd_write

  task automatic pulse_refresh(input logic win_side);
    if (win_side) begin
      wwd_ref = 1'b1;
    end else begin
      iwd_ref = 1'b1;
    end
    @(negedge core_clk);
    wwd_ref = 1'b0;
    iwd_ref = 1'b0;
    @(negedge core_clk);
  endtask : pulse_refresh

  task automatic iwd_write(input logic en, input logic [16:0] rl);
    iwd_en     = en;
    iwd_reload = rl;
    iwd_wr     = 1'b1;
    @(negedge core_clk);
    iwd_wr = 1'b0;
    @(negedge core_clk);
  endtask : iwd_write

  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_wwd_timeout();
    do_reset(1'b0, 1'b0);
    wwd_write(1'b0, 10'h003, 10'h3FF);
    check({30'h0, wwd_state}, {30'h0, st_idle});
    wwd_write(1'b1, 10'h003, 10'h3FF);
    check({30'h0, wwd_state}, {30'h0, st_run});
    check({22'h0, wwd_count}, 32'h3);
    wwd_write(1'b0, 10'h003, 10'h3FF);
    check({30'h0, wwd_state}, {30'h0, st_run});
    cpu_tick = 1'b1;
    // reload of three steps of four ticks: fires on the twelfth tick
    for (n = 0; n < 20 && wwd_state !== st_fired; n++) @(negedge core_clk);
    check({31'h0, n == 12}, 32'h1);
    // window request rises on the same edge as the fired state
    check({31'h0, rst_req}, 32'h1);
    @(negedge core_clk);
    check({31'h0, rst_req}, 32'h1);
    cpu_tick = 1'b0;
    pulse_refresh(1'b1);
    check({30'h0, wwd_state}, {30'h0, st_fired});
    $display("test wwd_timeout done");
  endtask : test_wwd_timeout

  task automatic test_wwd_window();
    do_reset(1'b0, 1'b0);
    wwd_write(1'b1, 10'h005, 10'h005);
    pulse_refresh(1'b1);
    check({30'h0, wwd_state}, {30'h0, st_run});
    cpu_tick = 1'b1;
    repeat (8) @(negedge core_clk);
    cpu_tick = 1'b0;
    check({31'h0, wwd_count < 10'h005}, 32'h1);
    pulse_refresh(1'b1);
    check({22'h0, wwd_count}, 32'h5);
    check({31'h0, rst_req}, 32'h0);
    do_reset(1'b1, 1'b0);
    check({30'h0, wwd_state}, {30'h0, st_run});
    check({22'h0, wwd_count}, 32'h5);
    wwd_write(1'b1, 10'h005, 10'h002);
    pulse_refresh(1'b1);
    check({30'h0, wwd_state}, {30'h0, st_fired});
    @(negedge core_clk);
    check({31'h0, rst_req}, 32'h1);
    $display("test wwd_window done");
  endtask : test_wwd_window

  task automatic test_iwd();
    // cpu clock failed: no cpu ticks through the whole test
    cpu_tick   = 1'b0;
    iwd_reload = 17'h00008;
    do_reset(1'b0, 1'b1);
    check({31'h0, iwd_active}, 32'h1);
    check({15'h0, iwd_count}, 32'h8);
    iwd_write(1'b0, 17'h00008);
    repeat (100) @(negedge core_clk);
    check({31'h0, iwd_active}, 32'h1);
    check({15'h0, iwd_count}, 32'h8);
    rc_run = 1'b1;
    for (n = 0; n < 500 && iwd_count !== 17'h00004; n++) @(negedge core_clk);
    check({15'h0, iwd_count}, 32'h4);
    pulse_refresh(1'b0);
    check({15'h0, iwd_count}, 32'h8);
    for (n = 0; n < 900 && iwd_fired !== 1'b1; n++) @(negedge core_clk);
    check({31'h0, n >= 500}, 32'h1);
    check({31'h0, iwd_fired}, 32'h1);
    // independent request follows its flag by one edge
    check({31'h0, rst_req}, 32'h0);
    @(negedge core_clk);
    check({31'h0, rst_req}, 32'h1);
    rc_run = 1'b0;
    do_reset(1'b0, 1'b0);
    iwd_write(1'b1, 17'h00003);
    check({15'h0, iwd_count}, 32'h8);
    do_reset(1'b0, 1'b0);
    iwd_write(1'b1, 17'h1FFFF);
    check({15'h0, iwd_count}, 32'h40);
    $display("test iwd done");
  endtask : test_iwd

  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails++;
      print_verdict();
    end
  end

  initial begin
    test_wwd_timeout();
    test_wwd_window();
    test_iwd();
    print_verdict();
  end

endmodule : tb

`default_nettype wire
